// [rtl/pwmart_core.sv]
// pwm auto-reload timer core with avalon-mm register slave
//
// Contract
// RULE_01: an 8-bit counter advances by one on every prescaled clock tick.
// RULE_02: software reads and overwrites the running count through counter_access_reg.
// RULE_03: on overflow the counter loads auto_reload_value while the prescaler runs on.
// RULE_04: a 7-bit prescaler divides the input clock by two to the prescale_select power.
// RULE_05: the input clock is the cpu clock or the external input, per ext_clock_select.
// RULE_06: with count_enable_bit clear counter and prescaler freeze, else they count.
// RULE_07: reset clears counter and prescaler and selects the cpu clock.
// RULE_08: force_reload plus count_enable_bit or a counter write sets count and clears prescaler.
// RULE_09: the prescaler has no software read or write path.
// RULE_10: four comparisons run between the counter and per-channel compare values.
// RULE_11: each hidden compare_shadow is copied from its duty_cycle_reg at every overflow.
// RULE_12: each output leaves its start level at compare match and returns at overflow.
`timescale 1ns/100ps
module pwmart_core #(
  parameter int CNT_W = pwmart_pkg::CNT_W,
  parameter int PRE_W = pwmart_pkg::PRE_W,
  parameter int NCH = pwmart_pkg::NCH
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [pwmart_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [pwmart_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [pwmart_pkg::BE_W-1:0] AVS_BYTEENABLE,
  output logic [pwmart_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EXT_CLK,
  output logic [NCH-1:0] PWM_OUT
);
  localparam int SEL_W = pwmart_pkg::SEL_W;

  pwmart_pkg::pwmart_bus_t bus_q;
  logic [pwmart_pkg::DATA_W-1:0] rdata_q;
  logic [pwmart_pkg::DATA_W-1:0] rdata_d;
  logic req;
  logic wr_acc;
  logic lane0;
  logic ctrl_wr;
  logic car_wr;
  logic arr_wr;
  logic frl_go;
  logic pre_clr;
  logic [NCH-1:0] duty_wr;

  logic count_enable_bit_q;
  logic ext_clock_select_q;
  logic [SEL_W-1:0] prescale_select_q;
  logic ovf_flag_q;
  logic [CNT_W-1:0] auto_reload_value_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] duty_cycle_reg_q [NCH];
  logic [CNT_W-1:0] compare_shadow [NCH];

  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic ext_rise;
  logic in_tick;
  logic pre_tick;
  logic [PRE_W-1:0] pre_cnt;
  logic ovf;

  // bus handshake: one wait cycle, then the access completes
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & (bus_q != pwmart_pkg::PWMART_BUS_ACK);
  assign wr_acc = AVS_WRITE & (bus_q == pwmart_pkg::PWMART_BUS_ACK);
  assign lane0 = wr_acc & AVS_BYTEENABLE[0];
  assign ctrl_wr = lane0 & (AVS_ADDRESS == pwmart_pkg::OFS_CTRL);
  assign car_wr = lane0 & (AVS_ADDRESS == pwmart_pkg::OFS_CAR);
  assign arr_wr = lane0 & (AVS_ADDRESS == pwmart_pkg::OFS_ARR);
  assign frl_go = ctrl_wr & AVS_WRITEDATA[pwmart_pkg::CTRL_FRL_BIT]
                  & AVS_WRITEDATA[pwmart_pkg::CTRL_EN_BIT];
  assign pre_clr = car_wr | frl_go; // [RULE_08]

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_q <= pwmart_pkg::PWMART_BUS_IDLE;
    end else begin
      case (bus_q)
        pwmart_pkg::PWMART_BUS_IDLE: begin
          if (req) begin
            bus_q <= pwmart_pkg::PWMART_BUS_ACK;
          end
        end
        pwmart_pkg::PWMART_BUS_ACK: begin
          bus_q <= pwmart_pkg::PWMART_BUS_IDLE;
        end
        default: begin
          bus_q <= pwmart_pkg::PWMART_BUS_IDLE;
        end
      endcase
    end
  end

  // read mux; the prescaler has no address, unmapped reads give zero
  always_comb begin
    rdata_d = '0;
    if (AVS_ADDRESS == pwmart_pkg::OFS_CTRL) begin
      rdata_d[pwmart_pkg::CTRL_EN_BIT] = count_enable_bit_q;
      rdata_d[pwmart_pkg::CTRL_SEL_LSB +: SEL_W] = prescale_select_q;
      rdata_d[pwmart_pkg::CTRL_EXT_BIT] = ext_clock_select_q;
      rdata_d[pwmart_pkg::CTRL_OVF_BIT] = ovf_flag_q;
    end else if (AVS_ADDRESS == pwmart_pkg::OFS_CAR) begin
      rdata_d[CNT_W-1:0] = cnt_q; // [RULE_02]
    end else if (AVS_ADDRESS == pwmart_pkg::OFS_ARR) begin
      rdata_d[CNT_W-1:0] = auto_reload_value_q;
    end
    for (int i = 0; i < NCH; i++) begin
      if (AVS_ADDRESS == pwmart_pkg::ADDR_W'(pwmart_pkg::OFS_DUTY0
          + pwmart_pkg::OFS_STEP * i)) begin
        rdata_d[CNT_W-1:0] = duty_cycle_reg_q[i];
      end
    end
  end // [RULE_09]

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= '0;
    end else if (AVS_READ & (bus_q == pwmart_pkg::PWMART_BUS_IDLE)) begin
      rdata_q <= rdata_d;
    end
  end
  assign AVS_READDATA = rdata_q;

  // control bits
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      count_enable_bit_q <= 1'b0;
      ext_clock_select_q <= 1'b0; // [RULE_07]
      prescale_select_q <= pwmart_pkg::SEL_RST;
    end else if (ctrl_wr) begin
      count_enable_bit_q <= AVS_WRITEDATA[pwmart_pkg::CTRL_EN_BIT];
      ext_clock_select_q <= AVS_WRITEDATA[pwmart_pkg::CTRL_EXT_BIT];
      prescale_select_q <= AVS_WRITEDATA[pwmart_pkg::CTRL_SEL_LSB +: SEL_W];
    end
  end

  // sticky overflow flag, write one to clear, a new overflow wins
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_flag_q <= 1'b0;
    end else if (ovf) begin
      ovf_flag_q <= 1'b1;
    end else if (ctrl_wr & AVS_WRITEDATA[pwmart_pkg::CTRL_OVF_BIT]) begin
      ovf_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      auto_reload_value_q <= pwmart_pkg::ARR_RST;
    end else if (arr_wr) begin
      auto_reload_value_q <= AVS_WRITEDATA[CNT_W-1:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      assign duty_wr[g] = lane0 & (AVS_ADDRESS == pwmart_pkg::ADDR_W'(
                          pwmart_pkg::OFS_DUTY0 + pwmart_pkg::OFS_STEP * g));
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          duty_cycle_reg_q[g] <= pwmart_pkg::DUTY_RST;
        end else if (duty_wr[g]) begin
          duty_cycle_reg_q[g] <= AVS_WRITEDATA[CNT_W-1:0];
        end
      end
      pwmart_pwm_chan #(
        .CNT_W(CNT_W)
      ) u_chan (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .ovf(ovf),
        .duty(duty_cycle_reg_q[g]),
        .cnt(cnt_q),
        .cmp(compare_shadow[g]),
        .pwm(PWM_OUT[g])
      ); // [RULE_10]
    end
  endgenerate

  // external clock pin: two-stage synchroniser, then edge detect
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= EXT_CLK;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  assign ext_rise = ext_s2_q & ~ext_s3_q;
  assign in_tick = ext_clock_select_q ? ext_rise : 1'b1; // [RULE_05]

  pwmart_prescaler #(
    .PRE_W(PRE_W),
    .SEL_W(SEL_W)
  ) u_pre (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .in_tick(in_tick),
    .run(count_enable_bit_q),
    .clr(pre_clr),
    .sel(prescale_select_q),
    .tick(pre_tick),
    .count(pre_cnt)
  ); // [RULE_04] [RULE_06]

  assign ovf = pre_tick & (cnt_q == pwmart_pkg::CNT_MAX) & ~pre_clr;

  // counter: bus write, forced reload, overflow reload, increment
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= pwmart_pkg::CNT_RST; // [RULE_07]
    end else if (car_wr) begin
      cnt_q <= AVS_WRITEDATA[CNT_W-1:0]; // [RULE_02] [RULE_08]
    end else if (frl_go) begin
      cnt_q <= auto_reload_value_q; // [RULE_08]
    end else if (ovf) begin
      cnt_q <= auto_reload_value_q; // [RULE_03]
    end else if (pre_tick) begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE_01]
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_cnt_step;
    pre_tick && (cnt_q != pwmart_pkg::CNT_MAX) && !pre_clr
      |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step) // [RULE_01]
    else $error("counter did not step on tick");

  property p_car_write;
    car_wr |=> (cnt_q == $past(AVS_WRITEDATA[CNT_W-1:0])) && (pre_cnt == '0);
  endproperty
  a_car_write: assert property (p_car_write) // [RULE_02]
    else $error("counter write not applied");

  property p_reload;
    ovf |=> (cnt_q == $past(auto_reload_value_q)) && ovf_flag_q;
  endproperty
  a_reload: assert property (p_reload) // [RULE_03]
    else $error("overflow reload wrong");

  property p_reload_presc;
    ovf && !ext_clock_select_q |=> pre_cnt == $past(pre_cnt) + 7'h01;
  endproperty
  a_reload_presc: assert property (p_reload_presc) // [RULE_03]
    else $error("prescaler disturbed by reload");

  property p_presc_tap;
    pre_tick |-> ((pre_cnt & PRE_W'((8'h01 << prescale_select_q) - 8'h01))
                  == PRE_W'((8'h01 << prescale_select_q) - 8'h01));
  endproperty
  a_presc_tap: assert property (p_presc_tap) // [RULE_04]
    else $error("tick at wrong prescaler tap");

  property p_cpu_clock;
    count_enable_bit_q && !ext_clock_select_q && !pre_clr
      |=> pre_cnt == $past(pre_cnt) + 7'h01;
  endproperty
  a_cpu_clock: assert property (p_cpu_clock) // [RULE_05]
    else $error("prescaler not fed by cpu clock");

  property p_freeze;
    !count_enable_bit_q && !car_wr && !frl_go && !arr_wr
      |=> $stable(cnt_q) && $stable(pre_cnt);
  endproperty
  a_freeze: assert property (p_freeze) // [RULE_06]
    else $error("counter moved while disabled");

  property p_force_reload;
    frl_go && !car_wr |=> (cnt_q == $past(auto_reload_value_q)) && (pre_cnt == '0);
  endproperty
  a_force_reload: assert property (p_force_reload) // [RULE_08]
    else $error("forced reload not applied");

  property p_shadow;
    ovf |=> compare_shadow[0] == $past(duty_cycle_reg_q[0]);
  endproperty
  a_shadow: assert property (p_shadow) // [RULE_11]
    else $error("compare shadow not loaded at overflow");

  property p_shadow_hold;
    !ovf |=> $stable(compare_shadow[1]);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) // [RULE_11]
    else $error("compare shadow changed between overflows");

  property p_pwm_match;
    !ovf && (cnt_q == compare_shadow[2]) |=> PWM_OUT[2] == ~pwmart_pkg::PWM_START;
  endproperty
  a_pwm_match: assert property (p_pwm_match) // [RULE_10]
    else $error("output did not change at compare match");

  property p_pwm_ovf;
    ovf |=> PWM_OUT == {NCH{pwmart_pkg::PWM_START}};
  endproperty
  a_pwm_ovf: assert property (p_pwm_ovf) // [RULE_12]
    else $error("outputs not restored at overflow");

  property p_bus_answer;
    req && (bus_q == pwmart_pkg::PWMART_BUS_IDLE) |=> !AVS_WAITREQUEST;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer late");

  property p_no_presc_read;
    AVS_READ && (AVS_ADDRESS > pwmart_pkg::ADDR_W'(pwmart_pkg::OFS_DUTY0
      + pwmart_pkg::OFS_STEP * (NCH - 1))) && (bus_q == pwmart_pkg::PWMART_BUS_IDLE)
      |=> AVS_READDATA == '0;
  endproperty
  a_no_presc_read: assert property (p_no_presc_read) // [RULE_09]
    else $error("unmapped read not zero");

  property p_stop_no_tick;
    !count_enable_bit_q |-> !pre_tick;
  endproperty
  a_stop_no_tick: assert property (p_stop_no_tick) // [RULE_06]
    else $error("prescaler ticked while disabled");

  property p_ext_tick_only;
    ext_clock_select_q && !ext_rise |-> !pre_tick;
  endproperty
  a_ext_tick_only: assert property (p_ext_tick_only) // [RULE_05]
    else $error("tick without an external clock edge");

  property p_rdata_hold;
    !(AVS_READ && (bus_q == pwmart_pkg::PWMART_BUS_IDLE)) |=> $stable(AVS_READDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed outside a read");

  property p_flag_clear;
    ctrl_wr && AVS_WRITEDATA[pwmart_pkg::CTRL_OVF_BIT] && !ovf |=> !ovf_flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("overflow flag not cleared by write");

  c_overflow: cover property (ovf ##1 ovf_flag_q);
  c_ext_tick: cover property (ext_clock_select_q && pre_tick);
  c_div128: cover property (pre_tick && (prescale_select_q == 3'h7));
  c_force: cover property (frl_go);
endmodule : pwmart_core

// [pkg/pwmart_pkg.sv]
// constants, register map and types of the pwm auto-reload timer
package pwmart_pkg;
  localparam int CNT_W = 8;
  localparam int PRE_W = 7;
  localparam int SEL_W = 3;
  localparam int NCH = 4;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // byte offsets on the register bus
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CAR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ARR = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_DUTY0 = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STEP = 5'h04;

  // timer_control_status fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FRL_BIT = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_EXT_BIT = 5;
  localparam int CTRL_OVF_BIT = 7;

  // reset values and the counter maximum
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] ARR_RST = 8'h00;
  localparam logic [CNT_W-1:0] DUTY_RST = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
  localparam logic [PRE_W-1:0] PRE_RST = 7'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic PWM_START = 1'b1;

  typedef enum logic [1:0] {
    PWMART_BUS_IDLE = 2'b01,
    PWMART_BUS_ACK = 2'b10
  } pwmart_bus_t;
endpackage : pwmart_pkg

// [rtl/pwmart_prescaler.sv]
// power-of-two prescaler with eight selectable taps
`timescale 1ns/100ps
module pwmart_prescaler #(
  parameter int PRE_W = pwmart_pkg::PRE_W,
  parameter int SEL_W = pwmart_pkg::SEL_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_tick,
  input wire logic run,
  input wire logic clr,
  input wire logic [SEL_W-1:0] sel,
  output logic tick,
  output logic [PRE_W-1:0] count
);
  logic [PRE_W:0] tap_w;
  logic [PRE_W-1:0] mask;

  // mask has sel low ones, so tick fires every 2**sel input ticks
  assign tap_w = {{PRE_W{1'b0}}, 1'b1} << sel;
  assign mask = tap_w[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1};
  assign tick = run & in_tick & ((count & mask) == mask); // [RULE_04]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= pwmart_pkg::PRE_RST; // [RULE_07]
    end else if (clr) begin
      count <= pwmart_pkg::PRE_RST; // [RULE_08]
    end else if (run & in_tick) begin
      count <= count + {{(PRE_W-1){1'b0}}, 1'b1}; // [RULE_06]
    end
  end
endmodule : pwmart_prescaler

// [rtl/pwmart_pwm_chan.sv]
// one pwm channel: shadow compare value and output level
`timescale 1ns/100ps
module pwmart_pwm_chan #(
  parameter int CNT_W = pwmart_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ovf,
  input wire logic [CNT_W-1:0] duty,
  input wire logic [CNT_W-1:0] cnt,
  output logic [CNT_W-1:0] cmp,
  output logic pwm
);
  // shadow copy taken only at overflow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp <= pwmart_pkg::DUTY_RST;
    end else if (ovf) begin
      cmp <= duty; // [RULE_11]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm <= pwmart_pkg::PWM_START;
    end else if (ovf) begin
      pwm <= pwmart_pkg::PWM_START; // [RULE_12]
    end else if (cnt == cmp) begin
      pwm <= ~pwmart_pkg::PWM_START; // [RULE_10] [RULE_12]
    end
  end
endmodule : pwmart_pwm_chan

// [bench/tb.sv]
// self-checking testbench of the pwm auto-reload timer core
`timescale 1ns/100ps
module tb;
  logic REF_CLK;
  logic RST_N;
  logic [pwmart_pkg::ADDR_W-1:0] AVS_ADDRESS;
  logic AVS_READ;
  logic AVS_WRITE;
  logic [pwmart_pkg::DATA_W-1:0] AVS_WRITEDATA;
  logic [pwmart_pkg::BE_W-1:0] AVS_BYTEENABLE;
  logic [pwmart_pkg::DATA_W-1:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic EXT_CLK;
  logic [3:0] PWM_OUT;
  int err_total;
  int cmp_count;
  int cyc;
  logic [31:0] exp_q[$];
  logic [7:0] lfsr;
  logic [7:0] dty [4];
  logic [7:0] r;

  pwmart_core pwmart_core_inst (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .EXT_CLK(EXT_CLK),
    .PWM_OUT(PWM_OUT)
  );

  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  // pseudo-random byte source
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // one avalon access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    int n;
    n = 0;
    @(posedge REF_CLK);
    AVS_READ <= rd;
    AVS_WRITE <= !rd;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h000000, d};
    AVS_BYTEENABLE <= 4'hF;
    if (rd) begin
      exp_q.push_back({24'h000000, e});
    end
    forever begin
      @(posedge REF_CLK);
      if (AVS_WAITREQUEST === 1'b0) begin
        break;
      end
      n++;
      if (n > 20) begin
        err_total++;
        end_sim();
      end
    end
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 8'h00);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b1, a, 8'h00, e);
  endtask : rd

  // control write that completes g edges after the previous access
  task automatic run_for(input int g, input logic [7:0] ctrl);
    repeat (g - 3) @(posedge REF_CLK);
    wr(pwmart_pkg::OFS_CTRL, ctrl);
  endtask : run_for

  function automatic logic [4:0] duty_addr(input int i);
    return pwmart_pkg::OFS_DUTY0 + pwmart_pkg::OFS_STEP * 5'(i);
  endfunction : duty_addr

  // count high cycles of each output over one 16-cycle period
  task automatic measure;
    int hi [4];
    for (int c = 0; c < 4; c++) hi[c] = 0;
    repeat (16) begin
      @(negedge REF_CLK);
      for (int c = 0; c < 4; c++) if (PWM_OUT[c] === 1'b1) hi[c]++;
    end
    for (int c = 0; c < 4; c++) begin
      check(32'(hi[c]), 32'(dty[c]) - 32'h000000F0 + 32'h00000001);
    end
  endtask : measure

  // result watcher: oldest noted read value against the data returned
  always @(posedge REF_CLK) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
      check(AVS_READDATA, exp_q.pop_front());
    end
  end

  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    RST_N = 1'b0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 5'h00;
    AVS_WRITEDATA = 32'h00000000;
    AVS_BYTEENABLE = 4'h0;
    EXT_CLK = 1'b0;
    lfsr = 8'h60;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (6) @(posedge REF_CLK);
    check({28'h0000000, PWM_OUT}, 32'h0000000F);
    RST_N <= 1'b1;
    // reset state and map
    rd(pwmart_pkg::OFS_CTRL, 8'h00);
    rd(pwmart_pkg::OFS_CAR, 8'h00);
    rd(pwmart_pkg::OFS_ARR, 8'h00);
    for (int i = 0; i < 4; i++) rd(duty_addr(i), 8'h00);
    wr(5'h1C, 8'hFF);
    rd(5'h1C, 8'h00);
    // counter access and control fields while stopped
    lfsr = nxt(lfsr);
    wr(pwmart_pkg::OFS_CAR, lfsr);
    rd(pwmart_pkg::OFS_CAR, lfsr);
    wr(pwmart_pkg::OFS_CTRL, 8'h3E);
    rd(pwmart_pkg::OFS_CTRL, 8'h3C);
    rd(pwmart_pkg::OFS_CAR, lfsr);
    // every prescaler tap, counter write clearing the prescaler
    for (int n = 0; n < 8; n++) begin
      wr(pwmart_pkg::OFS_CAR, 8'h00);
      wr(pwmart_pkg::OFS_CTRL, {3'b000, 3'(n), 2'b01});
      run_for(3 * (1 << n) + ((1 << n) >> 1), {3'b000, 3'(n), 2'b00});
      rd(pwmart_pkg::OFS_CAR, 8'h03);
    end
    // frozen while disabled, prescaler keeps its count
    repeat (300) @(posedge REF_CLK);
    rd(pwmart_pkg::OFS_CAR, 8'h03);
    wr(pwmart_pkg::OFS_CTRL, 8'h1D);
    run_for(100, 8'h1C);
    rd(pwmart_pkg::OFS_CAR, 8'h04);
    // force reload loads the reload value and clears the prescaler
    lfsr = nxt(lfsr);
    r = lfsr & 8'h7F;
    wr(pwmart_pkg::OFS_ARR, r);
    wr(pwmart_pkg::OFS_CTRL, 8'h0F);
    run_for(20, 8'h0C);
    rd(pwmart_pkg::OFS_CAR, r + 8'h02);
    rd(pwmart_pkg::OFS_CTRL, 8'h0C);
    // overflow reloads from the reload value
    lfsr = nxt(lfsr);
    r = lfsr & 8'h7F;
    wr(pwmart_pkg::OFS_ARR, r);
    wr(pwmart_pkg::OFS_CAR, 8'hFE);
    wr(pwmart_pkg::OFS_CTRL, 8'h01);
    run_for(4, 8'h00);
    rd(pwmart_pkg::OFS_CAR, r + 8'h02);
    rd(pwmart_pkg::OFS_CTRL, 8'h80);
    wr(pwmart_pkg::OFS_CTRL, 8'h80);
    rd(pwmart_pkg::OFS_CTRL, 8'h00);
    // external clock input counts its own rising edges only
    wr(pwmart_pkg::OFS_CAR, 8'h00);
    wr(pwmart_pkg::OFS_CTRL, 8'h21);
    for (int i = 0; i < 5; i++) begin
      repeat (8) @(posedge REF_CLK);
      EXT_CLK <= 1'b1;
      repeat (8) @(posedge REF_CLK);
      EXT_CLK <= 1'b0;
    end
    repeat (8) @(posedge REF_CLK);
    wr(pwmart_pkg::OFS_CTRL, 8'h20);
    rd(pwmart_pkg::OFS_CAR, 8'h05);
    // four pwm channels with a 16-count period
    wr(pwmart_pkg::OFS_ARR, 8'hF0);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      dty[i] = 8'hF0 + {4'h0, 4'(lfsr % 8'd15)};
      wr(duty_addr(i), dty[i]);
      rd(duty_addr(i), dty[i]);
    end
    wr(pwmart_pkg::OFS_CAR, 8'hF0);
    wr(pwmart_pkg::OFS_CTRL, 8'h01);
    repeat (40) @(posedge REF_CLK);
    measure();
    // duty change on the fly takes effect through the shadow
    dty[0] = 8'hFE - (dty[0] & 8'h07);
    wr(duty_addr(0), dty[0]);
    repeat (40) @(posedge REF_CLK);
    measure();
    wr(pwmart_pkg::OFS_CTRL, 8'h00);
    end_sim();
  end
endmodule : tb
